// File: src/hws_map.svh
// Summary of operation
// RULE1: Halt stops the system oscillator; watchdog oscillator keeps running if selected.
// RULE2: While halted, RAM, registers and port states are frozen.
// RULE3: Halt entry clears watchdog and prescaler when clocked from own oscillator.
// RULE4: Halt entry sets power_down_flag and clears timeout_flag.
// RULE5: Halt ends on pin reset, interrupt, port A fall or watchdog overflow.
// RULE6: Pin reset during halt fully initialises the device.
// RULE7: Watchdog timeout sets timeout_flag; in halt only PC and SP reset.
// RULE8: power_down_flag clears on power-up and on watchdog_clear_instruction.
// RULE9: Each port A line has its own build-time wake enable.
// RULE10: Port A wake resumes at the instruction after halt.
// RULE11: Interrupt wake resumes next unless enabled and stack not full.
// RULE12: Interrupt already flagged at halt entry cannot wake the device.
// RULE13: Every wake inserts a 1024 system clock dummy period.
// RULE14: After the delay, resume-next runs at once; interrupt entry may lag.
// RULE15: Startup delay on power-up and halt wake, including pin reset in halt; never for pin resets in normal operation.
// RULE16: Flags: 00 power-up, uu pin run, 01 pin halt, 1u wdt, 11 wdt halt.
// RULE17: Chip reset zeroes PC, disables interrupts, clears watchdog, ports input.
// RULE18: All resets but watchdog halt wake reload watchdog, port, interrupt defaults.
// RULE19: Watchdog timeout in normal operation causes a chip reset.
// RULE20: Watchdog on instruction clock stops during halt and cannot wake.
// RULE21: Port A and pin reset wake detection resynchronised when clock restarts.
`ifndef HWS_MAP_SVH
`define HWS_MAP_SVH
`define HWS_CLK_PERIOD_NS  5
`define HWS_STARTUP_CYCLES 1024
`define HWS_WDT_SEL_RESET  8'h07
`define HWS_PORT_RESET     8'hFF
`define HWS_INT_CTRL_RESET 8'h00
`define HWS_PC_RESET       10'h000
`define HWS_PA_WAKE_DEF    8'hFF
`endif

// File: src/hws_pkg.sv
package hws_pkg;
   typedef enum logic [3:0] {
      HWS_RUN   = 4'h1,
      HWS_HALT  = 4'h2,
      HWS_RESET = 4'h4,
      HWS_DELAY = 4'h8
   } hws_state_e;
endpackage

// File: src/hws_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "hws_map.svh"
module hws_sequencer
   import hws_pkg::*;
#(
   parameter logic [7:0]  PA_WAKE_EN     = `HWS_PA_WAKE_DEF,
   parameter int unsigned STARTUP_CYCLES = `HWS_STARTUP_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       ext_reset_n,
   input  wire logic       halt_instr,
   input  wire logic       wdt_clear_instr,
   input  wire logic       wdt_overflow,
   input  wire logic       wdt_enable,
   input  wire logic       wdt_src_osc,
   input  wire logic [7:0] pa_in,
   input  wire logic [1:0] int_flags,
   input  wire logic [1:0] int_enable,
   input  wire logic       int_master,
   input  wire logic       stack_full,
   output var  logic       osc_stop_r,
   output var  logic       hold_r,
   output var  logic       wdt_run_r,
   output var  logic       wdt_clear_r,
   output var  logic       chip_reset_r,
   output var  logic       warm_reset_r,
   output var  logic       reg_init_r,
   output var  logic [7:0] init_wdt_sel_r,
   output var  logic [7:0] init_port_r,
   output var  logic [7:0] init_int_ctrl_r,
   output var  logic [9:0] init_pc_r,
   output var  logic       resume_next_r,
   output var  logic       irq_entry_r,
   output var  logic       power_down_flag_r,
   output var  logic       timeout_flag_r
);
   hws_state_e state_r, state_nxt;
   logic       osc_stop_nxt, hold_nxt, wdt_run_nxt, wdt_clear_nxt;
   logic       chip_reset_nxt, warm_reset_nxt, reg_init_nxt;
   logic       resume_next_nxt, irq_entry_nxt;
   logic       pwr_flag_nxt, tmo_flag_nxt;
   logic       pin_halt_r, pin_halt_nxt;
   logic       go_next_r, go_next_nxt, go_irq_r, go_irq_nxt;
   logic [1:0] irq_armed_r, irq_armed_nxt;
   logic       dly_start_r, dly_start_nxt;
   logic [7:0] pa_prev_r;
   logic       dly_busy, dly_done;
   logic [7:0] pa_fall;
   logic [1:0] irq_new;
   logic       wdt_ovf_ok;
   logic       irq_take;

   function automatic logic is_halted(input hws_state_e s);
      return s == HWS_HALT;
   endfunction

   hws_startup_timer #(
      .CYCLES (STARTUP_CYCLES)
   ) u_dly (
      .clk    (clk),
      .srst   (srst),
      .start  (dly_start_r),
      .busy_r (dly_busy),
      .done_r (dly_done)
   );

   // Wake sources; inputs are already synchronous, so the previous sample
   // is the only stage needed once the oscillator runs again
   assign pa_fall = pa_prev_r & ~pa_in & PA_WAKE_EN; // RULE9 RULE21
   assign irq_new = int_flags & irq_armed_r; // RULE12
   assign wdt_ovf_ok = wdt_enable && wdt_overflow
                       && (!is_halted(state_r) || wdt_src_osc); // RULE20
   assign irq_take = int_master && |(irq_new & int_enable)
                     && !stack_full; // RULE11

   always_comb begin
      state_nxt       = state_r;
      osc_stop_nxt    = osc_stop_r;
      hold_nxt        = hold_r;
      wdt_run_nxt     = wdt_run_r;
      wdt_clear_nxt   = 1'b0;
      chip_reset_nxt  = 1'b0;
      warm_reset_nxt  = 1'b0;
      reg_init_nxt    = 1'b0;
      resume_next_nxt = 1'b0;
      irq_entry_nxt   = 1'b0;
      pwr_flag_nxt    = power_down_flag_r;
      tmo_flag_nxt    = timeout_flag_r;
      pin_halt_nxt    = pin_halt_r;
      go_next_nxt     = go_next_r;
      go_irq_nxt      = go_irq_r;
      irq_armed_nxt   = irq_armed_r;
      dly_start_nxt   = 1'b0;
      unique case (state_r)
         HWS_RUN: begin
            if (!ext_reset_n) begin
               state_nxt      = HWS_RESET; // RULE15 RULE16
               hold_nxt       = 1'b1;
               chip_reset_nxt = 1'b1; // RULE17
               reg_init_nxt   = 1'b1; // RULE18
               wdt_clear_nxt  = 1'b1;
               pin_halt_nxt   = 1'b0;
            end else if (wdt_ovf_ok) begin
               tmo_flag_nxt   = 1'b1; // RULE7 RULE16
               chip_reset_nxt = 1'b1; // RULE19
               reg_init_nxt   = 1'b1; // RULE18
               wdt_clear_nxt  = 1'b1;
            end else if (halt_instr) begin
               state_nxt     = HWS_HALT;
               osc_stop_nxt  = 1'b1; // RULE1
               hold_nxt      = 1'b1; // RULE2
               pwr_flag_nxt  = 1'b1; // RULE4
               tmo_flag_nxt  = 1'b0; // RULE4
               wdt_clear_nxt = wdt_src_osc; // RULE3
               wdt_run_nxt   = wdt_src_osc; // RULE20
               irq_armed_nxt = ~int_flags; // RULE12
            end else if (wdt_clear_instr) begin
               pwr_flag_nxt = 1'b0; // RULE8
            end
         end
         HWS_HALT: begin
            if (!ext_reset_n) begin
               state_nxt      = HWS_RESET; // RULE5 RULE6
               osc_stop_nxt   = 1'b0;
               chip_reset_nxt = 1'b1; // RULE6 RULE17
               reg_init_nxt   = 1'b1; // RULE18
               wdt_clear_nxt  = 1'b1;
               wdt_run_nxt    = 1'b1;
               pin_halt_nxt   = 1'b1;
               pwr_flag_nxt   = 1'b1; // RULE16
               tmo_flag_nxt   = 1'b0; // RULE16
               go_next_nxt    = 1'b0;
               go_irq_nxt     = 1'b0;
            end else if (wdt_ovf_ok || |irq_new || |pa_fall) begin
               state_nxt     = HWS_DELAY; // RULE5
               osc_stop_nxt  = 1'b0;
               wdt_run_nxt   = 1'b1;
               dly_start_nxt = 1'b1; // RULE13 RULE15
               if (wdt_ovf_ok) begin
                  // Warm wake: only PC and SP, no default reload
                  warm_reset_nxt = 1'b1; // RULE7
                  tmo_flag_nxt   = 1'b1; // RULE16
                  go_next_nxt    = 1'b0;
                  go_irq_nxt     = 1'b0;
               end else if (|irq_new) begin
                  go_irq_nxt  = irq_take; // RULE11
                  go_next_nxt = !irq_take; // RULE11
               end else begin
                  go_next_nxt = 1'b1; // RULE10
                  go_irq_nxt  = 1'b0;
               end
            end
         end
         HWS_RESET: begin
            if (ext_reset_n) begin
               if (pin_halt_r) begin
                  state_nxt     = HWS_DELAY; // RULE13
                  dly_start_nxt = 1'b1;
               end else begin
                  state_nxt = HWS_RUN; // RULE15
                  hold_nxt  = 1'b0;
               end
            end
         end
         HWS_DELAY: begin
            if (!ext_reset_n) begin
               state_nxt      = HWS_RESET;
               chip_reset_nxt = 1'b1;
               reg_init_nxt   = 1'b1;
               wdt_clear_nxt  = 1'b1;
               go_next_nxt    = 1'b0;
               go_irq_nxt     = 1'b0;
            end else if (dly_done) begin
               state_nxt       = HWS_RUN;
               hold_nxt        = 1'b0;
               resume_next_nxt = go_next_r; // RULE14
               irq_entry_nxt   = go_irq_r; // RULE14
               pin_halt_nxt    = 1'b0;
               go_next_nxt     = 1'b0;
               go_irq_nxt      = 1'b0;
            end
         end
         default: begin
            state_nxt = HWS_RUN;
            hold_nxt  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         // Power-up: full init with startup delay, flags 00
         state_r           <= HWS_DELAY; // RULE15
         osc_stop_r        <= 1'b0;
         hold_r            <= 1'b1;
         wdt_run_r         <= 1'b1;
         wdt_clear_r       <= 1'b1;
         chip_reset_r      <= 1'b1;
         warm_reset_r      <= 1'b0;
         reg_init_r        <= 1'b1;
         resume_next_r     <= 1'b0;
         irq_entry_r       <= 1'b0;
         power_down_flag_r <= 1'b0; // RULE8 RULE16
         timeout_flag_r    <= 1'b0;
         pin_halt_r        <= 1'b0;
         go_next_r         <= 1'b0;
         go_irq_r          <= 1'b0;
         irq_armed_r       <= 2'h0;
         dly_start_r       <= 1'b1;
         pa_prev_r         <= `HWS_PORT_RESET;
      end else begin
         state_r           <= state_nxt;
         osc_stop_r        <= osc_stop_nxt;
         hold_r            <= hold_nxt;
         wdt_run_r         <= wdt_run_nxt;
         wdt_clear_r       <= wdt_clear_nxt;
         chip_reset_r      <= chip_reset_nxt;
         warm_reset_r      <= warm_reset_nxt;
         reg_init_r        <= reg_init_nxt;
         resume_next_r     <= resume_next_nxt;
         irq_entry_r       <= irq_entry_nxt;
         power_down_flag_r <= pwr_flag_nxt;
         timeout_flag_r    <= tmo_flag_nxt;
         pin_halt_r        <= pin_halt_nxt;
         go_next_r         <= go_next_nxt;
         go_irq_r          <= go_irq_nxt;
         irq_armed_r       <= irq_armed_nxt;
         dly_start_r       <= dly_start_nxt;
         pa_prev_r         <= pa_in;
      end
   end

   // Default values, fixed so downstream loads need no decode of their own
   always_ff @(posedge clk) begin
      if (srst) begin
         init_wdt_sel_r  <= `HWS_WDT_SEL_RESET;
         init_port_r     <= `HWS_PORT_RESET;
         init_int_ctrl_r <= `HWS_INT_CTRL_RESET;
         init_pc_r       <= `HWS_PC_RESET;
      end else begin
         init_wdt_sel_r  <= `HWS_WDT_SEL_RESET; // RULE18
         init_port_r     <= `HWS_PORT_RESET; // RULE18
         init_int_ctrl_r <= `HWS_INT_CTRL_RESET; // RULE18
         init_pc_r   <= `HWS_PC_RESET; // RULE17
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   a_halt_entry : assert property ( // RULE4
      state_r == HWS_RUN && ext_reset_n && !wdt_ovf_ok && halt_instr
      |=> power_down_flag_r && !timeout_flag_r && osc_stop_r && hold_r)
      else $error("halt entry flags wrong");
   a_halt_wdt_clear : assert property ( // RULE3
      state_r == HWS_RUN && ext_reset_n && !wdt_ovf_ok && halt_instr
      |=> wdt_clear_r == $past(wdt_src_osc) && wdt_run_r == $past(wdt_src_osc))
      else $error("watchdog not cleared on halt");
   a_halt_frozen : assert property ( // RULE2
      state_r == HWS_HALT |-> hold_r && !chip_reset_r && !reg_init_r)
      else $error("state disturbed during halt");
   a_wdt_stopped : assert property ( // RULE20
      state_r == HWS_HALT && !wdt_src_osc && ext_reset_n
      && irq_new == 2'h0 && pa_fall == 8'h00 |=> state_r == HWS_HALT)
      else $error("instruction clock watchdog woke halt");
   a_pa_wake : assert property ( // RULE10
      state_r == HWS_HALT && ext_reset_n && !wdt_ovf_ok
      && irq_new == 2'h0 && pa_fall != 8'h00
      |=> state_r == HWS_DELAY && go_next_r ##1 dly_busy)
      else $error("port wake missed");
   a_warm_wake : assert property ( // RULE7
      state_r == HWS_HALT && ext_reset_n && wdt_ovf_ok
      |=> warm_reset_r && timeout_flag_r && power_down_flag_r
      && !reg_init_r && !chip_reset_r)
      else $error("warm wake wrong");
   a_pin_run_reset : assert property ( // RULE16
      state_r == HWS_RUN && !ext_reset_n
      |=> chip_reset_r && reg_init_r && $stable(power_down_flag_r)
      && $stable(timeout_flag_r))
      else $error("pin reset in run wrong");
   a_pin_no_delay : assert property ( // RULE15
      state_r == HWS_RESET && ext_reset_n && !pin_halt_r
      |=> state_r == HWS_RUN && !hold_r ##1 !dly_busy)
      else $error("pin reset got startup delay");
   a_pin_halt : assert property ( // RULE6
      state_r == HWS_HALT && !ext_reset_n
      |=> chip_reset_r && reg_init_r && power_down_flag_r && !timeout_flag_r)
      else $error("pin reset in halt wrong");
   a_pd_clear : assert property ( // RULE8
      state_r == HWS_RUN && ext_reset_n && !wdt_ovf_ok && !halt_instr
      && wdt_clear_instr |=> !power_down_flag_r)
      else $error("power down flag not cleared");
   a_resume : assert property ( // RULE14
      state_r == HWS_DELAY && ext_reset_n && dly_done
      |=> state_r == HWS_RUN && resume_next_r == $past(go_next_r)
      && irq_entry_r == $past(go_irq_r))
      else $error("resume after delay wrong");
   a_wdt_run_reset : assert property ( // RULE19
      state_r == HWS_RUN && ext_reset_n && wdt_ovf_ok
      |=> chip_reset_r && timeout_flag_r && wdt_clear_r)
      else $error("watchdog reset in run wrong");

   c_halt_wake : cover property (state_r == HWS_HALT ##1 state_r == HWS_DELAY);
   c_irq_entry : cover property (irq_entry_r);
   c_warm_wake : cover property (warm_reset_r);
   c_pin_halt  : cover property (state_r == HWS_HALT && !ext_reset_n);
endmodule
`default_nettype wire

// File: src/hws_startup_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "hws_map.svh"
module hws_startup_timer #(
   parameter int unsigned CYCLES = `HWS_STARTUP_CYCLES
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic start,
   output var  logic busy_r,
   output var  logic done_r
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES);
   localparam logic [CW-1:0] ONE  = CW'(1);

   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic          busy_nxt;
   logic          done_nxt;
   logic [CW:0]   len_r;

   if (CYCLES < 2) begin : g_bad_cycles
      $error("startup delay must be at least two cycles");
   end

   always_comb begin
      count_nxt = count_r;
      busy_nxt  = busy_r;
      done_nxt  = 1'b0;
      if (start) begin
         count_nxt = LOAD;
         busy_nxt  = 1'b1;
      end else if (busy_r) begin
         count_nxt = count_r - ONE;
         if (count_r == ONE) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         count_r <= '0;
         busy_r  <= 1'b0;
         done_r  <= 1'b0;
      end else begin
         count_r <= count_nxt;
         busy_r  <= busy_nxt;
         done_r  <= done_nxt;
      end
   end

   // Helper: length of each busy run
   always_ff @(posedge clk) begin
      // A restart while busy begins a fresh run
      if (srst || !busy_r || start) begin
         len_r <= '0;
      end else begin
         len_r <= len_r + 1'b1;
      end
   end

   a_startup_length : assert property (@(posedge clk) disable iff (srst) // RULE13
      $fell(busy_r) && !$past(start) |-> $past(len_r) == (CW+1)'(CYCLES - 1))
      else $error("startup delay length wrong");
   a_startup_done : assert property (@(posedge clk) disable iff (srst) // RULE15
      $fell(busy_r) && !$past(start) |-> done_r)
      else $error("startup delay end without done");
endmodule
`default_nettype wire

// File: tb/hws_wdt_model.sv
`timescale 1ns/1ps
`default_nettype none
module hws_wdt_model #(
   parameter int unsigned LIMIT = 20
) (
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic arm,
   input  wire logic run,
   input  wire logic clear,
   output var  logic overflow
);
   int unsigned cnt_r;
   // Counts only while the sequencer lets it; arm lets a scenario park it
   always @(posedge clk) begin
      overflow <= 1'h0;
      if (srst || clear) begin
         cnt_r <= 0;
      end else if (arm && run) begin
         if (cnt_r == LIMIT - 1) begin
            cnt_r    <= 0;
            overflow <= 1'h1;
         end else begin
            cnt_r <= cnt_r + 1;
         end
      end
   end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int DLY = 8;
   logic clk = 1'h0, srst = 1'h1, ext_reset_n = 1'h1, halt_instr = 1'h0;
   logic wdt_clear_instr = 1'h0, wdt_enable = 1'h1, wdt_src_osc = 1'h1;
   logic arm = 1'h0, int_master = 1'h0, stack_full = 1'h0;
   logic [7:0] pa_in = 8'hFF;
   logic [1:0] int_flags = 2'h0, int_enable = 2'h0;
   wire logic wdt_overflow, osc_stop_r, hold_r, wdt_run_r, wdt_clear_r;
   wire logic chip_reset_r, warm_reset_r, reg_init_r, resume_next_r;
   wire logic irq_entry_r, pwr_flag, tmo_flag;
   wire logic [7:0] init_wdt_sel_r, init_port_r, init_int_ctrl_r;
   wire logic [9:0] init_pc_r;
   logic [4:0] seen = 5'h00;
   int n_fail = 0, n_checks = 0;

   always #2.5 clk = ~clk;

   hws_wdt_model wdt_u (.clk(clk), .srst(srst), .arm(arm), .run(wdt_run_r),
      .clear(wdt_clear_r), .overflow(wdt_overflow));

   hws_sequencer #(.PA_WAKE_EN(8'hFE), .STARTUP_CYCLES(DLY)) dut_u (
      .clk(clk), .srst(srst), .ext_reset_n(ext_reset_n),
      .halt_instr(halt_instr), .wdt_clear_instr(wdt_clear_instr),
      .wdt_overflow(wdt_overflow), .wdt_enable(wdt_enable),
      .wdt_src_osc(wdt_src_osc), .pa_in(pa_in), .int_flags(int_flags),
      .int_enable(int_enable), .int_master(int_master),
      .stack_full(stack_full), .osc_stop_r(osc_stop_r), .hold_r(hold_r),
      .wdt_run_r(wdt_run_r), .wdt_clear_r(wdt_clear_r),
      .chip_reset_r(chip_reset_r), .warm_reset_r(warm_reset_r),
      .reg_init_r(reg_init_r), .init_wdt_sel_r(init_wdt_sel_r),
      .init_port_r(init_port_r), .init_int_ctrl_r(init_int_ctrl_r),
      .init_pc_r(init_pc_r), .resume_next_r(resume_next_r),
      .irq_entry_r(irq_entry_r), .power_down_flag_r(pwr_flag),
      .timeout_flag_r(tmo_flag));

   // One-cycle pulses are latched here so no scenario can miss them
   always @(posedge clk) begin
      seen <= seen | {chip_reset_r, warm_reset_r, reg_init_r,
                      resume_next_r, irq_entry_r};
   end

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %b got %b", nm, e, g);
      end
   endtask

   task automatic chk_vec(input string nm, input logic [9:0] e,
                          input logic [9:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_cnt(input string nm, input int lo, input int hi,
                          input int g);
      n_checks++;
      if (g < lo || g > hi) begin
         n_fail++;
         $display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Bounded, so a design that never wakes ends up out of range
   task automatic wait_hold(output int n);
      n = 0;
      while (hold_r !== 1'h0 && n < 300) begin
         tick(1);
         n++;
      end
      // One more edge, so seen has latched the pulse that ends the hold
      tick(1);
   endtask

   task automatic do_halt;
      @(posedge clk);
      halt_instr <= 1'h1;
      @(posedge clk);
      halt_instr <= 1'h0;
      #1 chk_bit("halt wdt clear", wdt_src_osc, wdt_clear_r);
      tick(2);
      seen = 5'h00;
      chk_bit("osc_stop", 1'h1, osc_stop_r);
      chk_bit("pwr flag halt", 1'h1, pwr_flag);
      chk_bit("tmo flag halt", 1'h0, tmo_flag);
   endtask

   task automatic t_reset;
      int n;
      repeat (10) @(posedge clk);
      srst <= 1'h0;
      wait_hold(n);
      chk_cnt("power-up delay", DLY, DLY + 4, n);
      chk_vec("pulses", 10'h014, {5'h00, seen & 5'h1C});
      chk_vec("flags", 10'h000, {8'h00, tmo_flag, pwr_flag});
      chk_vec("wdt select", 10'h007, {2'h0, init_wdt_sel_r});
      chk_vec("port", 10'h0FF, {2'h0, init_port_r});
      chk_vec("int ctrl", 10'h000, {2'h0, init_int_ctrl_r});
      chk_vec("pc", 10'h000, init_pc_r);
   endtask

   task automatic t_halt_port;
      int n;
      do_halt();
      @(posedge clk);
      pa_in <= 8'hFE;
      tick(20);
      chk_bit("masked line", 1'h1, osc_stop_r);
      @(posedge clk);
      pa_in <= 8'hF6;
      wait_hold(n);
      chk_cnt("port wake delay", DLY, DLY + 6, n);
      chk_bit("osc restart", 1'h0, osc_stop_r);
      chk_vec("port wake", 10'h002, {5'h00, seen});
      @(posedge clk);
      pa_in <= 8'hFF;
   endtask

   task automatic t_halt_irq(input logic full, input logic [4:0] exp);
      int n;
      @(posedge clk);
      int_master <= 1'h1;
      int_enable <= 2'h3;
      stack_full <= full;
      int_flags  <= 2'h1;
      do_halt();
      tick(20);
      chk_bit("stale flag", 1'h1, osc_stop_r);
      @(posedge clk);
      int_flags <= 2'h3;
      wait_hold(n);
      chk_cnt("irq wake delay", DLY, DLY + 6, n);
      chk_vec("irq wake", {5'h00, exp}, {5'h00, seen});
      @(posedge clk);
      int_flags <= 2'h0;
   endtask

   task automatic t_halt_wdt;
      int n;
      @(posedge clk);
      wdt_src_osc <= 1'h1;
      arm <= 1'h1;
      do_halt();
      wait_hold(n);
      chk_cnt("wdt wake", DLY, 60, n);
      chk_vec("wdt flags", 10'h003, {8'h00, tmo_flag, pwr_flag});
      chk_vec("warm only", 10'h008, {5'h00, seen});
      @(posedge clk);
      arm <= 1'h0;
   endtask

   task automatic t_wdt_run;
      int i;
      // A disabled watchdog may overflow in the model but must not reset
      @(posedge clk);
      wdt_enable <= 1'h0;
      arm <= 1'h1;
      #1 seen = 5'h00;
      tick(30);
      chk_bit("wdt disabled", 1'h0, seen[4]);
      @(posedge clk);
      wdt_enable <= 1'h1;
      #1 seen = 5'h00;
      for (i = 0; i < 40 && seen[4] !== 1'h1; i++) tick(1);
      @(posedge clk);
      arm <= 1'h0;
      tick(2);
      chk_vec("run wdt", 10'h014, {5'h00, seen & 5'h1C});
      chk_vec("run flags", 10'h003, {8'h00, tmo_flag, pwr_flag});
      chk_bit("no halt", 1'h0, osc_stop_r);
      @(posedge clk);
      wdt_clear_instr <= 1'h1;
      @(posedge clk);
      wdt_clear_instr <= 1'h0;
      tick(2);
      chk_bit("pwr flag clear", 1'h0, pwr_flag);
   endtask

   task automatic t_halt_pin;
      int n;
      @(posedge clk);
      wdt_src_osc <= 1'h0;
      arm <= 1'h1;
      do_halt();
      tick(40);
      chk_bit("wdt stopped", 1'h0, wdt_run_r);
      chk_bit("no wdt wake", 1'h1, osc_stop_r);
      @(posedge clk);
      ext_reset_n <= 1'h0;
      tick(3);
      chk_vec("pin halt", 10'h014, {5'h00, seen & 5'h1C});
      chk_vec("pin flags", 10'h001, {8'h00, tmo_flag, pwr_flag});
      @(posedge clk);
      ext_reset_n <= 1'h1;
      arm <= 1'h0;
      #1 seen = 5'h00;
      wait_hold(n);
      chk_cnt("pin halt delay", DLY, DLY + 6, n);
      chk_vec("no resume", 10'h000, {8'h00, seen[1:0]});
   endtask

   task automatic t_pin_run;
      int n;
      @(posedge clk);
      ext_reset_n <= 1'h0;
      #1 seen = 5'h00;
      tick(3);
      chk_vec("pin run", 10'h014, {5'h00, seen & 5'h1C});
      @(posedge clk);
      ext_reset_n <= 1'h1;
      wait_hold(n);
      chk_cnt("no pin delay", 0, 3, n);
      chk_vec("kept flags", 10'h001, {8'h00, tmo_flag, pwr_flag});
   endtask

   task automatic test_done;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #150000;
      n_fail++;
      test_done();
   end

   initial begin
      t_reset();
      t_halt_port();
      t_halt_irq(1'h0, 5'h01);
      t_halt_irq(1'h1, 5'h02);
      t_halt_wdt();
      t_wdt_run();
      t_halt_pin();
      t_pin_run();
      test_done();
   end
endmodule
`default_nettype wire
